// *** hw/flash_cmd_pkg.sv ***
// Constants shared by the serial flash command front end.
// Operation
// - Modifying instructions need the write-enable latch set by an earlier command.
// - Latch clears at power-up and after disable, status write, program or erase.
// - Block-protect bits make a region read-only against program and erase.
// - Bottom layout protects from address zero upward, growing with the code.
// - Top layout protects from the array top downward, growing with the code.
// - Write-protect low with status-protect set freezes protect and status-protect bits.
// - In deep sleep only the release instruction is obeyed.
// - Pause never stops a running internal cycle and keeps the bit count.
// - Pause starts and ends on the pause edge, or when clock next goes low.
// - While paused the output floats and clock and data are ignored.
// - Deselect during pause resets the interface; pause must rise before reselect.
// - Bits are taken on rising clock edges, most significant bit first.
// - Read-type instructions end on any deselect; others after their final bit.
// - Write-type instructions execute only if deselect falls on a byte boundary.
// - A program ending mid-byte does nothing and keeps the latch set.
// - Program needs four bytes after opcode; sector erase exactly three.
// - While an internal cycle runs, array access attempts are ignored.
// - Opcodes 06h enable, 04h disable, 01h status write with one byte.
// - 05h streams status, 03h reads, 0Bh reads after one dummy byte.
// - 02h programs a page, D8h erases a sector, C7h erases everything.
// - B9h enters deep sleep; ABh releases and returns identifier after dummies.
// - 90h returns maker and device after three bytes; 9Fh returns three bytes.
// - Status-protect set with write-protect low refuses status writes.
// - Busy bit reads one during an internal cycle, zero otherwise.
package flash_cmd_pkg;
  localparam logic [7:0]  OP_WENA_C  = 8'h06; // write_enable_cmd
  localparam logic [7:0]  OP_WDIS_C  = 8'h04; // write_disable_cmd
  localparam logic [7:0]  OP_SWR_C   = 8'h01; // status_write_cmd
  localparam logic [7:0]  OP_SRD_C   = 8'h05; // status_read_cmd
  localparam logic [7:0]  OP_READ_C  = 8'h03;
  localparam logic [7:0]  OP_FREAD_C = 8'h0B;
  localparam logic [7:0]  OP_PROG_C  = 8'h02; // page_program_cmd
  localparam logic [7:0]  OP_SERA_C  = 8'hD8; // sector_erase_cmd
  localparam logic [7:0]  OP_BERA_C  = 8'hC7; // bulk_erase_cmd
  localparam logic [7:0]  OP_SLEEP_C = 8'hB9; // deep_sleep_cmd
  localparam logic [7:0]  OP_WAKE_C  = 8'hAB; // wake_release_cmd / wake_and_id_cmd
  localparam logic [7:0]  OP_MDID_C  = 8'h90;
  localparam logic [7:0]  OP_JID_C   = 8'h9F;
  // Byte counts, opcode included, at which frames change phase, and the count at which the byte counter saturates.
  localparam logic [3:0]  CNT_OP_C   = 4'h1;
  localparam logic [3:0]  CNT_SWR_C  = 4'h2;
  localparam logic [3:0]  CNT_ADDR_C = 4'h4;
  localparam logic [3:0]  CNT_FAST_C = 4'h5;
  localparam logic [3:0]  CNT_MAX_C  = 4'hF;
  // Status byte layout.
  localparam int          SB_BUSY_C  = 0;
  localparam int          SB_LATCH_C = 1;
  localparam int          SB_BP_LO_C = 2;
  localparam int          SB_LOCK_C  = 7;
  // Array geometry: smallest protect region is one 4 KB sector.
  localparam int          AW_C       = 18;
  localparam logic [17:0] SECT4K_C   = 18'h01000;
  localparam logic [2:0]  BP_ALL_C   = 3'h7;
  localparam logic [2:0]  BP_NONE_C  = 3'h0;
endpackage : flash_cmd_pkg

// *** hw/serial_flash_cmd_protect.sv ***
// Command front end of the serial flash: framing, decode, protection and pause.
`timescale 1ns/10ps
module serial_flash_cmd_protect #(
  parameter bit         TOP_BOOT    = 1'b0,
  parameter int         BUSY_CYCLES = 64,
  parameter logic [7:0] MAKER_ID    = 8'hA5, // Arbitrary value.
  parameter logic [7:0] DEV_ID_BOT  = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEV_ID_TOP  = 8'h5B, // Arbitrary value.
  parameter logic [7:0] JID_HI      = 8'h3C, // Arbitrary value.
  parameter logic [7:0] JID_LO      = 8'hC3  // Arbitrary value.
) (
  // System
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Serial link pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        serial_in,
  input  wire logic        pause_n,
  input  wire logic        wp_n,
  output logic             serial_out,
  output logic             serial_out_oe,
  // Array side
  input  wire logic [7:0]  arr_rdata,
  output logic [23:0]      arr_addr,
  output logic             prog_byte_stb,
  output logic [7:0]       prog_byte,
  output logic             prog_go,
  output logic             erase_go,
  output logic             bulk_go,
  // Status
  output logic [7:0]       status_byte,
  output logic             deep_sleep
);

  typedef struct packed {
    logic        sclk_m, sclk_s, sclk_d;
    logic        cs_m, cs_s, cs_d;
    logic        din_m, din_s;
    logic        pause_m, pause_s;
    logic        wp_m, wp_s;
    logic        active;
    logic        hold_act;
    logic        hold_lock;
    logic [2:0]  bits;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [23:0] rd_addr;
    logic [7:0]  out_sr;
    logic        out_live;
    logic        load_pend;
    logic [1:0]  id_idx;
    logic        so;
    logic        so_oe;
    logic        asleep;
    logic        write_enable_latch;
    logic [2:0]  bp;
    logic        status_protect_bit;
    logic        busy;
    logic [15:0] bcnt;
    logic        prog_go, erase_go, bulk_go;
    logic        prog_stb;
    logic [7:0]  prog_byte;
  } state_s;

  localparam state_s RESET_C = '{sclk_m: 1'b0, sclk_s: 1'b0, sclk_d: 1'b0,
                                 cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1,
                                 pause_m: 1'b1, pause_s: 1'b1,
                                 wp_m: 1'b1, wp_s: 1'b1, default: '0};

  state_s st_r, st_nxt;

  localparam logic [17:0] SECT4K_C = flash_cmd_pkg::SECT4K_C;

  // Protected-region test; regions are sector aligned, so one address settles it.
  function automatic logic prot_hit(input logic [23:0] a, input logic [2:0] code);
    logic [17:0] span;
    span = SECT4K_C << (3'(code - 3'h1));
    if (code == flash_cmd_pkg::BP_NONE_C) begin
      prot_hit = 1'b0;
    end else if (code == flash_cmd_pkg::BP_ALL_C) begin
      prot_hit = 1'b1;
    end else if (TOP_BOOT) begin
      prot_hit = a[flash_cmd_pkg::AW_C-1:0] >= 18'(18'h0 - span);
    end else begin
      prot_hit = a[flash_cmd_pkg::AW_C-1:0] < span;
    end
  endfunction : prot_hit

  logic       rise, fall, cs_rise, cs_fall, hard_protected_mode, aligned, can_mod;
  logic [7:0] byte_in;
  logic [7:0] stat;

  always_comb begin
    st_nxt   = st_r;
    // Synchronisers; the first stage feeds only the second.
    st_nxt.sclk_m  = sclk;
    st_nxt.sclk_s  = st_r.sclk_m;
    st_nxt.sclk_d  = st_r.sclk_s;
    st_nxt.cs_m    = cs_n;
    st_nxt.cs_s    = st_r.cs_m;
    st_nxt.cs_d    = st_r.cs_s;
    st_nxt.din_m   = serial_in;
    st_nxt.din_s   = st_r.din_m;
    st_nxt.pause_m = pause_n;
    st_nxt.pause_s = st_r.pause_m;
    st_nxt.wp_m    = wp_n;
    st_nxt.wp_s    = st_r.wp_m;
    st_nxt.prog_go  = 1'b0;
    st_nxt.erase_go = 1'b0;
    st_nxt.bulk_go  = 1'b0;
    st_nxt.prog_stb = 1'b0;
    st_nxt.load_pend = 1'b0;

    rise    = st_r.sclk_s & ~st_r.sclk_d;
    fall    = ~st_r.sclk_s & st_r.sclk_d;
    cs_rise = st_r.cs_s & ~st_r.cs_d;
    cs_fall = ~st_r.cs_s & st_r.cs_d;
    hard_protected_mode = st_r.status_protect_bit & ~st_r.wp_s;
    aligned = st_r.bits == 3'h0;
    can_mod = st_r.write_enable_latch & ~st_r.busy & ~st_r.asleep;
    byte_in = {st_r.sh[6:0], st_r.din_s};
    stat    = '0;
    stat[flash_cmd_pkg::SB_BUSY_C] = st_r.busy;
    stat[flash_cmd_pkg::SB_LATCH_C] = st_r.write_enable_latch;
    stat[flash_cmd_pkg::SB_BP_LO_C +: 3] = st_r.bp;
    stat[flash_cmd_pkg::SB_LOCK_C] = st_r.status_protect_bit;

    // Internal cycle timer runs regardless of pause or selection.
    if (st_r.busy) begin
      st_nxt.bcnt = st_r.bcnt - 16'h1;
      if (st_r.bcnt == 16'h1) begin
        st_nxt.busy = 1'b0;
        st_nxt.write_enable_latch = 1'b0;
      end
    end

    // Pause takes effect only while the clock is low, entry and exit alike.
    if (st_r.active && !st_r.sclk_s) begin
      st_nxt.hold_act = ~st_r.pause_s;
    end
    if (st_r.cs_s && st_r.pause_s) begin
      st_nxt.hold_lock = 1'b0;
    end

    if (cs_fall && !st_r.hold_lock) begin
      st_nxt.active   = 1'b1;
      st_nxt.bits     = '0;
      st_nxt.cnt      = '0;
      st_nxt.out_live = 1'b0;
      st_nxt.id_idx   = '0;
    end else if (cs_rise && st_r.active) begin
      st_nxt.active   = 1'b0;
      st_nxt.out_live = 1'b0;
      st_nxt.hold_act = 1'b0;
      if (st_r.hold_act) begin
        st_nxt.hold_lock = 1'b1;
      end else if (st_r.asleep) begin
        if (st_r.op == flash_cmd_pkg::OP_WAKE_C && st_r.cnt != '0 && aligned) begin
          st_nxt.asleep = 1'b0;
        end
      end else if (aligned) begin
        unique case (st_r.op)
          flash_cmd_pkg::OP_WENA_C:
            if (st_r.cnt == flash_cmd_pkg::CNT_OP_C) st_nxt.write_enable_latch = 1'b1;
          flash_cmd_pkg::OP_WDIS_C:
            if (st_r.cnt == flash_cmd_pkg::CNT_OP_C) st_nxt.write_enable_latch = 1'b0;
          flash_cmd_pkg::OP_SLEEP_C:
            if (st_r.cnt == flash_cmd_pkg::CNT_OP_C) st_nxt.asleep = 1'b1;
          flash_cmd_pkg::OP_SWR_C:
            if (st_r.cnt == flash_cmd_pkg::CNT_SWR_C && can_mod
                && !hard_protected_mode) begin
              st_nxt.bp   = st_r.addr[flash_cmd_pkg::SB_BP_LO_C +: 3];
              st_nxt.status_protect_bit = st_r.addr[flash_cmd_pkg::SB_LOCK_C];
              st_nxt.busy = 1'b1;
              st_nxt.bcnt = 16'(BUSY_CYCLES);
            end
          flash_cmd_pkg::OP_PROG_C:
            if (st_r.cnt > flash_cmd_pkg::CNT_ADDR_C && can_mod) begin
              if (prot_hit(st_r.addr, st_r.bp)) begin
                st_nxt.write_enable_latch = 1'b0;
              end else begin
                st_nxt.prog_go = 1'b1;
                st_nxt.busy    = 1'b1;
                st_nxt.bcnt    = 16'(BUSY_CYCLES);
              end
            end
          flash_cmd_pkg::OP_SERA_C:
            if (st_r.cnt == flash_cmd_pkg::CNT_ADDR_C && can_mod) begin
              if (prot_hit(st_r.addr, st_r.bp)) begin
                st_nxt.write_enable_latch = 1'b0;
              end else begin
                st_nxt.erase_go = 1'b1;
                st_nxt.busy     = 1'b1;
                st_nxt.bcnt     = 16'(BUSY_CYCLES);
              end
            end
          flash_cmd_pkg::OP_BERA_C:
            if (st_r.cnt == flash_cmd_pkg::CNT_OP_C && can_mod) begin
              if (st_r.bp != flash_cmd_pkg::BP_NONE_C) begin
                st_nxt.write_enable_latch = 1'b0;
              end else begin
                st_nxt.bulk_go = 1'b1;
                st_nxt.busy    = 1'b1;
                st_nxt.bcnt    = 16'(BUSY_CYCLES);
              end
            end
          default: begin
          end
        endcase
      end
      // A program frame that ends mid-byte falls through with the latch untouched.
    end else if (st_r.active && !st_r.hold_act) begin
      if (rise) begin
        st_nxt.sh   = byte_in;
        st_nxt.bits = st_r.bits + 3'h1;
        if (st_r.bits == 3'h7) begin
          st_nxt.cnt = (st_r.cnt == flash_cmd_pkg::CNT_MAX_C) ? st_r.cnt
                                                               : st_r.cnt + 4'h1;
          st_nxt.load_pend = 1'b1;
          if (st_r.cnt == '0) begin
            st_nxt.op = byte_in;
          end else if (st_r.cnt < flash_cmd_pkg::CNT_ADDR_C) begin
            st_nxt.addr = {st_r.addr[15:0], byte_in};
          end
          if (st_r.op == flash_cmd_pkg::OP_PROG_C && st_r.cnt >= flash_cmd_pkg::CNT_ADDR_C
              && !st_r.asleep && !st_r.busy) begin
            st_nxt.prog_stb  = 1'b1;
            st_nxt.prog_byte = byte_in;
          end
          if ((st_r.op == flash_cmd_pkg::OP_READ_C
               && st_r.cnt + 4'h1 >= flash_cmd_pkg::CNT_ADDR_C)
              || (st_r.op == flash_cmd_pkg::OP_FREAD_C
               && st_r.cnt + 4'h1 >= flash_cmd_pkg::CNT_FAST_C)) begin
            // For 03h the last address byte lands in this same cycle, so the updated address is used.
            st_nxt.rd_addr = (st_r.cnt + 4'h1 == flash_cmd_pkg::CNT_ADDR_C
                              || (st_r.op == flash_cmd_pkg::OP_FREAD_C
                              && st_r.cnt + 4'h1 == flash_cmd_pkg::CNT_FAST_C))
                             ? st_nxt.addr : st_r.rd_addr + 24'h1;
          end
        end
      end else if (fall && st_r.out_live) begin
        st_nxt.so     = st_r.out_sr[7];
        st_nxt.out_sr = {st_r.out_sr[6:0], 1'b0};
      end
    end

    // Load the next output byte one cycle after a byte boundary, so array data is settled.
    if (st_r.load_pend && st_r.active) begin
      st_nxt.out_live = 1'b1;
      unique case (st_r.op)
        flash_cmd_pkg::OP_SRD_C:
          st_nxt.out_sr = stat;
        flash_cmd_pkg::OP_READ_C:
          st_nxt.out_sr = arr_rdata;
        flash_cmd_pkg::OP_FREAD_C:
          st_nxt.out_sr = arr_rdata;
        flash_cmd_pkg::OP_WAKE_C:
          st_nxt.out_sr = TOP_BOOT ? DEV_ID_TOP : DEV_ID_BOT;
        flash_cmd_pkg::OP_MDID_C:
          st_nxt.out_sr = st_r.cnt[0] ? (TOP_BOOT ? DEV_ID_TOP : DEV_ID_BOT)
                                      : MAKER_ID;
        flash_cmd_pkg::OP_JID_C: begin
          st_nxt.out_sr = (st_r.id_idx == 2'h0) ? MAKER_ID
                        : (st_r.id_idx == 2'h1) ? JID_HI : JID_LO;
          st_nxt.id_idx = (st_r.id_idx == 2'h2) ? 2'h0 : st_r.id_idx + 2'h1;
        end
        default:
          st_nxt.out_live = 1'b0;
      endcase
      if (st_r.cnt < flash_cmd_pkg::CNT_ADDR_C
          && st_r.op != flash_cmd_pkg::OP_SRD_C && st_r.op != flash_cmd_pkg::OP_JID_C) begin
        st_nxt.out_live = 1'b0;
      end
      if (st_r.op == flash_cmd_pkg::OP_FREAD_C && st_r.cnt < flash_cmd_pkg::CNT_FAST_C) begin
        st_nxt.out_live = 1'b0;
      end
      if ((st_r.asleep && st_r.op != flash_cmd_pkg::OP_WAKE_C)
          || (st_r.busy && (st_r.op == flash_cmd_pkg::OP_READ_C
                            || st_r.op == flash_cmd_pkg::OP_FREAD_C))) begin
        st_nxt.out_live = 1'b0;
      end
    end

    st_nxt.so_oe = st_nxt.active & ~st_nxt.hold_act & st_nxt.out_live;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= RESET_C;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign serial_out    = st_r.so;
  assign serial_out_oe = st_r.so_oe;
  assign arr_addr      = st_r.rd_addr;
  assign prog_byte_stb = st_r.prog_stb;
  assign prog_byte     = st_r.prog_byte;
  assign prog_go       = st_r.prog_go;
  assign erase_go      = st_r.erase_go;
  assign bulk_go       = st_r.bulk_go;
  assign deep_sleep    = st_r.asleep;
  assign status_byte   = {st_r.status_protect_bit, 2'h0, st_r.bp, st_r.write_enable_latch,
                          st_r.busy};

  chk_go_needs_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r.prog_go || st_r.erase_go || st_r.bulk_go) |-> st_r.write_enable_latch)
    else $error("Modify started without write enable latch");
  chk_busy_on_go: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r.prog_go || st_r.erase_go) |-> st_r.busy ##1 st_r.busy)
    else $error("Busy not held after start");
  chk_latch_clear_end: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(st_r.busy) |-> !st_r.write_enable_latch)
    else $error("Latch still set after cycle end");
  chk_bulk_needs_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_r.bulk_go |-> $past(st_r.bp) == 3'h0)
    else $error("Bulk erase with protection set");
  chk_prog_unprot: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r.prog_go || st_r.erase_go) |-> !prot_hit(st_r.addr, st_r.bp))
    else $error("Protected region targeted");
  chk_hard_freeze: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(st_r.status_protect_bit && !st_r.wp_s)
    |-> $stable(st_r.bp) && $stable(st_r.status_protect_bit))
    else $error("Protect bits changed in hardware protected mode");
  chk_sleep_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(st_r.asleep) |-> !st_r.prog_go && !st_r.erase_go && !st_r.bulk_go && !st_r.prog_stb)
    else $error("Instruction obeyed in deep sleep");
  chk_pause_float: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_r.hold_act |-> !st_r.so_oe)
    else $error("Output driven during pause");
  chk_pause_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r.hold_act && $past(st_r.hold_act) && st_r.active) |-> $stable(st_r.bits))
    else $error("Bit count moved during pause");
  chk_busy_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(st_r.busy) |-> st_r.busy[*8])
    else $error("Internal cycle cut short");
  chk_busy_read_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r.busy && (st_r.op == flash_cmd_pkg::OP_READ_C || st_r.op == flash_cmd_pkg::OP_FREAD_C))
    |-> !st_r.so_oe)
    else $error("Array read answered during internal cycle");

endmodule : serial_flash_cmd_protect

// *** test/spi_host_model.sv ***
// Host SPI master model that frames instructions for the flash front end.
`timescale 1ns/10ps
module spi_host_model (
  // System
  input  wire logic clk_sys,
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_in,
  output logic      pause_n,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic       oe_any;
  logic       oe_pause;

  initial begin
    sclk      = 1'b0;
    cs_n      = 1'b1;
    serial_in = 1'b1;
    pause_n   = 1'b1;
  end

  // Four system clocks make half of the 200 ns link period.
  task automatic half;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : half

  // Stalls the link mid-frame while clock and data wiggle as noise.
  task automatic stall;
    pause_n = 1'b0;
    half();
    repeat (2) begin
      sclk      = 1'b1;
      serial_in = ~serial_in;
      half();
      oe_pause  = oe_pause | serial_out_oe;
      sclk      = 1'b0;
      half();
    end
    pause_n = 1'b1;
    half();
  endtask : stall

  // Sends tx_q MSB first plus spare bits; the bit at pause_at follows a stall.
  task automatic run(input int spare, input int pause_at);
    logic [7:0] r;
    int         nb;
    r        = 8'h00;
    nb       = tx_q.size() * 8 + spare;
    oe_any   = 1'b0;
    oe_pause = 1'b0;
    rx_q.delete();
    cs_n = 1'b0;
    half();
    for (int n = 0; n < nb; n++) begin
      if (n == pause_at) stall();
      serial_in = (n < tx_q.size() * 8) ? tx_q[n / 8][7 - n % 8] : 1'b0;
      half();
      sclk   = 1'b1;
      r      = {r[6:0], serial_out};
      oe_any = oe_any | serial_out_oe;
      half();
      sclk = 1'b0;
      if (n % 8 == 7) rx_q.push_back(r);
    end
    // A released data line shows the inverse of its last value.
    serial_in = ~serial_in;
    half();
    cs_n = 1'b1;
    half();
    half();
  endtask : run
endmodule : spi_host_model

// *** test/serial_flash_cmd_protect_bench.sv ***
// Self-checking bench for the serial flash command front end.
`timescale 1ns/10ps
module serial_flash_cmd_protect_bench;
  localparam int         BUSY_C = 1024;
  localparam logic [7:0] MAKER  = 8'h6E; // Arbitrary value.
  localparam logic [7:0] DEV    = 8'h29; // Arbitrary value.
  localparam logic [7:0] JHI    = 8'h47; // Arbitrary value.
  localparam logic [7:0] JLO    = 8'hB2; // Arbitrary value.
  logic        clk_sys, nrst, sclk, cs_n, serial_in, pause_n, wp_n, serial_out;
  logic        serial_out_oe, prog_byte_stb, prog_go, erase_go, bulk_go, deep_sleep;
  logic [7:0]  arr_rdata, prog_byte, status_byte, last_prog;
  logic [23:0] arr_addr;
  int          fails, checks_done, cyc, prog_n, erase_n, bulk_n, stb_n;

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Array content is a simple function of the address so reads are predictable.
  assign arr_rdata = arr_addr[7:0] ^ 8'h3C;

  serial_flash_cmd_protect #(
    .TOP_BOOT(1'b0), .BUSY_CYCLES(BUSY_C), .MAKER_ID(MAKER), .DEV_ID_BOT(DEV),
    .DEV_ID_TOP(8'h11), .JID_HI(JHI), .JID_LO(JLO)
  ) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .pause_n(pause_n), .wp_n(wp_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .arr_rdata(arr_rdata), .arr_addr(arr_addr), .prog_byte_stb(prog_byte_stb),
    .prog_byte(prog_byte), .prog_go(prog_go), .erase_go(erase_go), .bulk_go(bulk_go),
    .status_byte(status_byte), .deep_sleep(deep_sleep)
  );

  spi_host_model host_u (
    .clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .pause_n(pause_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe)
  );

  always @(posedge clk_sys) begin
    if (prog_go === 1'b1) prog_n++;
    if (erase_go === 1'b1) erase_n++;
    if (bulk_go === 1'b1) bulk_n++;
    if (prog_byte_stb === 1'b1) begin
      stb_n++;
      last_prog = prog_byte;
    end
    cyc++;
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cmd1(input logic [7:0] op);
    host_u.tx_q = '{op};
    host_u.run(0, -1);
  endtask : cmd1

  // Waits for the internal cycle to end, bounded just past its length.
  task automatic idle;
    for (int i = 0; i < 1200 && status_byte[0] !== 1'b0; i++) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic swr(input logic [7:0] v);
    cmd1(flash_cmd_pkg::OP_WENA_C);
    host_u.tx_q = '{flash_cmd_pkg::OP_SWR_C, v};
    host_u.run(0, -1);
    check({7'h00, status_byte[0]}, 8'h01);
    idle();
  endtask : swr

  task automatic t_latch;
    check(status_byte, 8'h00);
    cmd1(flash_cmd_pkg::OP_WENA_C);
    check(status_byte, 8'h02);
    host_u.tx_q = '{flash_cmd_pkg::OP_SRD_C, 8'h00, 8'h00};
    host_u.run(0, 12);
    check(host_u.rx_q[1], 8'h02);
    check(host_u.rx_q[2], 8'h02);
    check({7'h00, host_u.oe_pause}, 8'h00);
    cmd1(flash_cmd_pkg::OP_WDIS_C);
    check(status_byte, 8'h00);
    host_u.tx_q = '{flash_cmd_pkg::OP_WENA_C};
    host_u.run(1, -1);
    check(status_byte, 8'h00);
    host_u.run(0, 3);
    check(status_byte, 8'h02);
  endtask : t_latch

  task automatic t_prog;
    swr(8'h18);
    check(status_byte, 8'h18);
    cmd1(flash_cmd_pkg::OP_WENA_C);
    host_u.tx_q = '{flash_cmd_pkg::OP_PROG_C, 8'h01, 8'hFF, 8'hFF, 8'hA5};
    host_u.run(0, -1);
    check(prog_n[7:0], 8'h00);
    check(status_byte, 8'h18);
    cmd1(flash_cmd_pkg::OP_WENA_C);
    host_u.tx_q = '{flash_cmd_pkg::OP_PROG_C, 8'h02, 8'h00, 8'h00};
    host_u.run(0, -1);
    check(status_byte, 8'h1A);
    host_u.tx_q = '{flash_cmd_pkg::OP_PROG_C, 8'h02, 8'h00, 8'h00, 8'hA5};
    host_u.run(3, -1);
    check(status_byte, 8'h1A);
    check(prog_n[7:0], 8'h00);
    host_u.tx_q = '{flash_cmd_pkg::OP_PROG_C, 8'h02, 8'h00, 8'h00, 8'hA5, 8'h5A};
    host_u.run(0, -1);
    check(prog_n[7:0], 8'h01);
    check(stb_n[7:0], 8'h04);
    check(last_prog, 8'h5A);
    host_u.tx_q = '{flash_cmd_pkg::OP_READ_C, 8'h00, 8'h00, 8'h00, 8'h00};
    host_u.run(0, -1);
    check({7'h00, host_u.oe_any}, 8'h00);
    idle();
    check(status_byte, 8'h18);
  endtask : t_prog

  task automatic t_erase;
    cmd1(flash_cmd_pkg::OP_WENA_C);
    host_u.tx_q = '{flash_cmd_pkg::OP_SERA_C, 8'h03, 8'h00, 8'h00, 8'h00};
    host_u.run(0, -1);
    check(erase_n[7:0], 8'h00);
    cmd1(flash_cmd_pkg::OP_WENA_C);
    host_u.tx_q = '{flash_cmd_pkg::OP_SERA_C, 8'h03, 8'h00, 8'h00};
    host_u.run(0, -1);
    check(erase_n[7:0], 8'h01);
    idle();
    cmd1(flash_cmd_pkg::OP_WENA_C);
    cmd1(flash_cmd_pkg::OP_BERA_C);
    check(bulk_n[7:0], 8'h00);
  endtask : t_erase

  task automatic t_hard_prot;
    swr(8'h98);
    wp_n = 1'b0;
    cmd1(flash_cmd_pkg::OP_WENA_C);
    host_u.tx_q = '{flash_cmd_pkg::OP_SWR_C, 8'h00};
    host_u.run(0, -1);
    check(status_byte & 8'hFD, 8'h98);
    check(status_byte & 8'hFC, 8'h98);
    wp_n = 1'b1;
    swr(8'h00);
    check(status_byte, 8'h00);
    cmd1(flash_cmd_pkg::OP_WENA_C);
    cmd1(flash_cmd_pkg::OP_BERA_C);
    check(bulk_n[7:0], 8'h01);
    idle();
  endtask : t_hard_prot

  task automatic t_sleep;
    cmd1(flash_cmd_pkg::OP_SLEEP_C);
    check({7'h00, deep_sleep}, 8'h01);
    cmd1(flash_cmd_pkg::OP_WENA_C);
    check(status_byte, 8'h00);
    host_u.tx_q = '{flash_cmd_pkg::OP_JID_C, 8'h00, 8'h00, 8'h00};
    host_u.run(0, -1);
    check({7'h00, host_u.oe_any}, 8'h00);
    host_u.tx_q = '{flash_cmd_pkg::OP_WAKE_C, 8'h00, 8'h00, 8'h00, 8'h00};
    host_u.run(0, -1);
    check(host_u.rx_q[4], DEV);
    check({7'h00, deep_sleep}, 8'h00);
  endtask : t_sleep

  task automatic t_ids;
    host_u.tx_q = '{flash_cmd_pkg::OP_JID_C, 8'h00, 8'h00, 8'h00};
    host_u.run(0, -1);
    check(host_u.rx_q[1], MAKER);
    check(host_u.rx_q[2], JHI);
    check(host_u.rx_q[3], JLO);
    host_u.tx_q = '{flash_cmd_pkg::OP_MDID_C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    host_u.run(0, -1);
    check(host_u.rx_q[4], MAKER);
    check(host_u.rx_q[5], DEV);
    host_u.tx_q = '{flash_cmd_pkg::OP_READ_C, 8'h00, 8'h12, 8'h34, 8'h00, 8'h00};
    host_u.run(0, -1);
    check(host_u.rx_q[4], 8'h34 ^ 8'h3C);
    check(host_u.rx_q[5], 8'h35 ^ 8'h3C);
    host_u.tx_q = '{flash_cmd_pkg::OP_FREAD_C, 8'h00, 8'h12, 8'h34, 8'h00, 8'h00};
    host_u.run(0, -1);
    check(host_u.rx_q[5], 8'h34 ^ 8'h3C);
  endtask : t_ids

  task automatic final_report;
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    nrst = 1'b0;
    wp_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_latch();
    t_prog();
    t_erase();
    t_hard_prot();
    t_sleep();
    t_ids();
    final_report();
  end
endmodule : serial_flash_cmd_protect_bench
